// File: hdl/eth_clk_ctrl_pkg.sv
// Package for the Ethernet clock-domain control block.
// Assumes a 250 MHz system clock and an APB register port with 32-bit data.
package eth_clk_ctrl_pkg;

    // Register byte offsets.
    localparam logic [11:0] DOMAIN_STATE_OFS   = 12'h000;
    localparam logic [11:0] MODULE_CTRL_OFS    = 12'h004;
    localparam logic [11:0] LINK_CFG_OFS       = 12'h008;
    localparam logic [11:0] STATUS_OFS         = 12'h00C;
    localparam logic [11:0] DISABLED_HOURS_OFS = 12'h010;

    // Field positions.
    localparam int TRANS_CTRL_LSB = 0;
    localparam int MOD_MODE_LSB   = 0;
    localparam int SPEED_LSB      = 0;

    // Transition control encodings.
    localparam logic [1:0] TRANS_NONE  = 2'h0;
    localparam logic [1:0] TRANS_SLEEP = 2'h1;
    localparam logic [1:0] TRANS_WAKE  = 2'h2;

    // Module mode encodings.
    localparam logic [1:0] MODE_DISABLED = 2'h0;
    localparam logic [1:0] MODE_ENABLED  = 2'h2;

    // Link speed encodings.
    localparam logic [1:0] SPEED_10   = 2'h0;
    localparam logic [1:0] SPEED_100  = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;

    // Reset values: clock source disabled after reset.
    localparam logic [1:0] TRANS_RESET = TRANS_NONE;
    localparam logic [1:0] MODE_RESET  = MODE_DISABLED;
    localparam logic [1:0] SPEED_RESET = SPEED_10;

    // Timing.
    localparam int  SYS_CLK_MHZ       = 250;
    localparam int  SECONDS_PER_HOUR  = 3600;
    localparam int  DISABLED_LIMIT_HR = 200;
    localparam logic [39:0] CYCLES_PER_HOUR =
        40'(64'(SYS_CLK_MHZ) * 64'd1000000 * 64'(SECONDS_PER_HOUR));

    // Register read or write request from the bus slave.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    // Clock control state shown to status reads.
    typedef struct packed {
        logic       ethClkOn;
        logic       moduleOff;
        logic       limitExceeded;
        logic       ethClkPhase;
    } clk_stat_t;

endpackage

// File: hdl/apb_reg_port.sv
// APB slave front end: turns APB transfers into one-cycle register requests.
// Assumes the APB master shares sys_clk; answers with zero wait states.
`timescale 1ns/10ps
module apb_reg_port (
    // Clock and reset.
    input  wire logic                        sys_clk,
    input  wire logic                        reset,
    // APB slave.
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output      logic                        pready,
    // Register side.
    output      eth_clk_ctrl_pkg::reg_req_t  req
);
    import eth_clk_ctrl_pkg::*;

    logic access;

    // Ready is high in every access phase; the transfer completes in it.
    always_comb begin
        pready = 1'b1;
        access = psel & penable & ~reset;
        req.wr    = access & pwrite;
        req.rd    = access & ~pwrite;
        req.addr  = paddr;
        req.wdata = pwdata;
    end

endmodule

// File: hdl/eth_tx_launch.sv
// Gigabit transmit launch: clock on the rising phase, control and data on the
// falling phase of the internal source. Assumes clkOn gates the source.
`timescale 1ns/10ps
module eth_tx_launch (
    // Clock and reset.
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // Control.
    input  wire logic       clkOn,
    input  wire logic       gigMode,
    input  wire logic [4:0] txIn,
    // Outputs.
    output      logic       phase_ff,
    output      logic       txClk_ff,
    output      logic [4:0] txOut_ff
);
    import eth_clk_ctrl_pkg::*;

    logic       nxt_phase;
    logic       nxt_txClk;
    logic [4:0] nxt_txOut;

    // The internal source is sys_clk divided by two; phase high is its high half.
    always_comb begin
        nxt_phase = clkOn ? ~phase_ff : 1'b0;
        nxt_txClk = txClk_ff;
        nxt_txOut = txOut_ff;
        if (!clkOn) begin
            nxt_txClk = 1'b0;
        end else if (gigMode) begin
            nxt_txClk = nxt_phase;
            if (!nxt_phase) begin
                nxt_txOut = txIn;
            end
        end else begin
            // Slower modes are edge-agnostic: data follows the clock rise.
            nxt_txClk = nxt_phase;
            if (nxt_phase) begin
                nxt_txOut = txIn;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            phase_ff <= 1'b0;
            txClk_ff <= 1'b0;
            txOut_ff <= 5'h00;
        end else begin
            phase_ff <= nxt_phase;
            txClk_ff <= nxt_txClk;
            txOut_ff <= nxt_txOut;
        end
    end

endmodule

// File: hdl/eth_clk_ctrl.sv
// Ethernet clock-domain and module-mode control with APB registers.
// Assumes APB on sys_clk (250 MHz) and a transmit source on the same clock.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module eth_clk_ctrl (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output      logic [31:0] prdata_ff,
    output      logic        pready_ff,
    output      logic        pslverr_ff,
    // Transmit data from the MAC.
    input  wire logic [4:0]  txIn,
    // Clock enables and transmit pins.
    output      logic        ethClkEn_ff,
    output      logic        interconnectClkEn_ff,
    output      logic        modulePowerOn_ff,
    output      logic        txClk_ff,
    output      logic [4:0]  txOut_ff
);
    import eth_clk_ctrl_pkg::*;

    eth_clk_ctrl_pkg::reg_req_t req;
    logic                       pReadyRaw;
    clk_stat_t                  stat;

    apb_reg_port u_apb (
        .sys_clk (sys_clk),
        .reset   (reset),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pready  (pReadyRaw),
        .req     (req)
    );

    // Register state.
    logic [1:0]  transCtrl_ff;
    logic [1:0]  modMode_ff;
    logic [1:0]  speed_ff;
    logic [39:0] hourCycles_ff;
    logic [15:0] disabledHours_ff;
    logic [1:0]  nxt_transCtrl;
    logic [1:0]  nxt_modMode;
    logic [1:0]  nxt_speed;
    logic [39:0] nxt_hourCycles;
    logic [15:0] nxt_disabledHours;

    // Bus answer state.
    logic [31:0] nxt_prdata;
    logic        nxt_pready;
    logic        nxt_pslverr;

    // Clock outputs.
    logic nxt_ethClkEn;
    logic nxt_modulePowerOn;
    logic gigMode;
    logic txPhase;

    // Returns true for a known register offset.
    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == DOMAIN_STATE_OFS) || (a == MODULE_CTRL_OFS) ||
                   (a == LINK_CFG_OFS) || (a == STATUS_OFS) ||
                   (a == DISABLED_HOURS_OFS);
    endfunction

    // Control register writes.
    always_comb begin
        nxt_transCtrl = transCtrl_ff;
        nxt_modMode   = modMode_ff;
        nxt_speed     = speed_ff;
        if (req.wr) begin
            if (req.addr == DOMAIN_STATE_OFS) begin
                nxt_transCtrl = req.wdata[TRANS_CTRL_LSB +: 2];
            end else if (req.addr == MODULE_CTRL_OFS) begin
                nxt_modMode = req.wdata[MOD_MODE_LSB +: 2];
            end else if (req.addr == LINK_CFG_OFS) begin
                nxt_speed = req.wdata[SPEED_LSB +: 2];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            transCtrl_ff <= TRANS_RESET;
            modMode_ff   <= MODE_RESET;
            speed_ff     <= SPEED_RESET;
        end else begin
            transCtrl_ff <= nxt_transCtrl;
            modMode_ff   <= nxt_modMode;
            speed_ff     <= nxt_speed;
        end
    end

    // Clock gating decisions.
    always_comb begin
        // Clock runs only when the module is enabled and the domain is not asleep.
        nxt_ethClkEn = (modMode_ff == MODE_ENABLED) &&
                       (transCtrl_ff != TRANS_SLEEP);
        // Disabled mode with forced sleep powers the MAC down.
        nxt_modulePowerOn = !((modMode_ff == MODE_DISABLED) &&
                              (transCtrl_ff == TRANS_SLEEP));
        gigMode = (speed_ff == SPEED_1000);
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ethClkEn_ff          <= 1'b0;
            modulePowerOn_ff     <= 1'b1;
            interconnectClkEn_ff <= 1'b1;
        end else begin
            ethClkEn_ff          <= nxt_ethClkEn;
            modulePowerOn_ff     <= nxt_modulePowerOn;
            // The interconnect clock has no gating path at all.
            interconnectClkEn_ff <= 1'b1;
        end
    end

    // Disabled-time accounting in whole hours, while the gigabit link is selected.
    always_comb begin
        nxt_hourCycles    = hourCycles_ff;
        nxt_disabledHours = disabledHours_ff;
        if (gigMode && !ethClkEn_ff) begin
            if (hourCycles_ff == CYCLES_PER_HOUR - 40'h1) begin
                nxt_hourCycles = 40'h0;
                if (disabledHours_ff != 16'hFFFF) begin
                    nxt_disabledHours = disabledHours_ff + 16'h1;
                end
            end else begin
                nxt_hourCycles = hourCycles_ff + 40'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            hourCycles_ff    <= 40'h0;
            disabledHours_ff <= 16'h0;
        end else begin
            hourCycles_ff    <= nxt_hourCycles;
            disabledHours_ff <= nxt_disabledHours;
        end
    end

    eth_tx_launch u_tx (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .clkOn    (ethClkEn_ff),
        .gigMode  (gigMode),
        .txIn     (txIn),
        .phase_ff (txPhase),
        .txClk_ff (txClk_ff),
        .txOut_ff (txOut_ff)
    );

    always_comb begin
        stat.ethClkOn      = ethClkEn_ff;
        stat.moduleOff     = ~modulePowerOn_ff;
        stat.limitExceeded = (disabledHours_ff > 16'(DISABLED_LIMIT_HR));
        stat.ethClkPhase   = txPhase;
    end

    // Read mux and bus answer.
    always_comb begin
        nxt_prdata  = prdata_ff;
        nxt_pready  = 1'b0;
        nxt_pslverr = 1'b0;
        if (psel && !pready_ff) begin
            nxt_pready = pReadyRaw & ~reset;
            nxt_prdata = 32'h0000_0000;
            if (!addr_hit(paddr)) begin
                nxt_pslverr = 1'b1;
            end else if (!pwrite) begin
                if (paddr == DOMAIN_STATE_OFS) begin
                    nxt_prdata = {30'h0, transCtrl_ff};
                end else if (paddr == MODULE_CTRL_OFS) begin
                    nxt_prdata = {30'h0, modMode_ff};
                end else if (paddr == LINK_CFG_OFS) begin
                    nxt_prdata = {30'h0, speed_ff};
                end else if (paddr == STATUS_OFS) begin
                    nxt_prdata = {28'h0, stat};
                end else begin
                    nxt_prdata = {16'h0, disabledHours_ff};
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

endmodule

// File: tb/eth_clk_ctrl_assertions.sv
// Checker for eth_clk_ctrl, bound to the top module's ports.
// Assumes register writes land in the APB access cycle.
`timescale 1ns/10ps
module eth_clk_ctrl_assertions (
    // Clock, reset and APB.
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata_ff,
    input wire logic        pready_ff,
    // Transmit path and clock enables.
    input wire logic [4:0]  txIn,
    input wire logic        ethClkEn_ff,
    input wire logic        interconnectClkEn_ff,
    input wire logic        modulePowerOn_ff,
    input wire logic        txClk_ff,
    input wire logic [4:0]  txOut_ff
);
    import eth_clk_ctrl_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic [1:0] trans_ff;
    logic [1:0] mode_ff;
    logic [1:0] speed_ff;
    logic [2:0] quiet_ff;
    logic       wr;
    logic       want;
    logic       calm;
    assign wr = psel && penable && pwrite;
    assign want = (mode_ff == MODE_ENABLED) && (trans_ff != TRANS_SLEEP);
    assign calm = (quiet_ff == 3'h7);
    // Mirrors the written fields; quiet_ff counts edges since the last write and holds at 7.
    always_ff @(posedge sys_clk) begin
        quiet_ff <= (reset || wr) ? 3'h0 : (calm ? quiet_ff : quiet_ff + 3'h1);
        if (reset) begin
            trans_ff <= TRANS_RESET;
            mode_ff  <= MODE_RESET;
            speed_ff <= SPEED_RESET;
        end else if (wr && paddr == DOMAIN_STATE_OFS) begin
            trans_ff <= pwdata[1:0];
        end else if (wr && paddr == MODULE_CTRL_OFS) begin
            mode_ff <= pwdata[1:0];
        end else if (wr && paddr == LINK_CFG_OFS) begin
            speed_ff <= pwdata[1:0];
        end
    end
    a_clk_gate:
        assert property (calm |-> ethClkEn_ff == want) else $error("clock enable wrong");
    a_power_off:
        assert property (calm |-> modulePowerOn_ff == !(mode_ff == MODE_DISABLED && trans_ff == TRANS_SLEEP))
            else $error("module power state wrong");
    a_tx_toggle:
        assert property (calm && ethClkEn_ff |-> txClk_ff != $past(txClk_ff)) else $error("txClk not toggling");
    a_data_phase:
        assert property (calm && ethClkEn_ff && speed_ff == SPEED_1000 && $changed(txOut_ff) |-> !txClk_ff)
            else $error("gigabit data moved on rising phase");
    a_slow_data:
        assert property (calm && ethClkEn_ff && speed_ff != SPEED_1000 && txClk_ff |-> txOut_ff == $past(txIn))
            else $error("slow data not taken on clock rise");
    a_slow_hold:
        assert property (calm && ethClkEn_ff && speed_ff != SPEED_1000 && !txClk_ff |-> $stable(txOut_ff))
            else $error("slow data moved on clock fall");
    a_trans_read:
        assert property (pready_ff && !pwrite && paddr == DOMAIN_STATE_OFS |-> prdata_ff == {30'h0, trans_ff})
            else $error("transition field readback wrong");
    a_mode_read:
        assert property (pready_ff && !pwrite && paddr == MODULE_CTRL_OFS |-> prdata_ff == {30'h0, mode_ff})
            else $error("module mode readback wrong");
    a_ic_on:
        assert property (interconnectClkEn_ff) else $error("interconnect clock gated");
    a_apb_answer:
        assert property (psel && !penable |-> ##1 pready_ff ##1 !pready_ff) else $error("pready timing wrong");
endmodule

bind eth_clk_ctrl eth_clk_ctrl_assertions u_chk (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata_ff, .pready_ff, .txIn, .ethClkEn_ff, .interconnectClkEn_ff, .modulePowerOn_ff, .txClk_ff, .txOut_ff);

// File: tb/tb_top.sv
// Self-checking bench for eth_clk_ctrl.
// Assumes one 250 MHz clock and an APB slave ending each transfer with pready_ff.
`timescale 1ns/10ps
module tb_top;
    import eth_clk_ctrl_pkg::*;
    logic        sys_clk;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [4:0]  txIn;
    logic        ethClkEn_ff;
    logic        interconnectClkEn_ff;
    logic        modulePowerOn_ff;
    logic        txClk_ff;
    logic [4:0]  txOut_ff;
    logic [31:0] rd;
    logic        er;
    int          errorCnt;
    int          numChecks;

    eth_clk_ctrl DUT (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_ff, .pready_ff,
        .pslverr_ff, .txIn, .ethClkEn_ff, .interconnectClkEn_ff, .modulePowerOn_ff, .txClk_ff, .txOut_ff);

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) txIn <= reset ? 5'h00 : txIn + 5'h01;

    task automatic reportAndStop();
        $display("Checks %0d, mismatches %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        numChecks++;
        if (g !== e) begin
            errorCnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer; holds the request until pready_ff is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready_ff !== 1'b1);
        rd = prdata_ff;
        er = pslverr_ff;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic t_reset();
        chk("ethClkEn", 32'h0, 32'(ethClkEn_ff));
        chk("interconnectClkEn", 32'h1, 32'(interconnectClkEn_ff));
        apb(1'b0, DOMAIN_STATE_OFS, 32'h0);
        chk("domainState", 32'(TRANS_RESET), rd);
        apb(1'b0, MODULE_CTRL_OFS, 32'h0);
        chk("moduleCtrl", 32'(MODE_RESET), rd);
    endtask
    task automatic t_wake();
        logic t;
        apb(1'b1, DOMAIN_STATE_OFS, 32'(TRANS_WAKE));
        repeat (3) @(posedge sys_clk);
        chk("ethClkEn half", 32'h0, 32'(ethClkEn_ff));
        apb(1'b1, MODULE_CTRL_OFS, 32'(MODE_ENABLED));
        repeat (3) @(posedge sys_clk);
        chk("ethClkEn on", 32'h1, 32'(ethClkEn_ff));
        t = txClk_ff;
        @(posedge sys_clk);
        chk("txClk toggle", {31'h0, ~t}, 32'(txClk_ff));
        apb(1'b0, DOMAIN_STATE_OFS, 32'h0);
        chk("domainState", 32'(TRANS_WAKE), rd);
        apb(1'b0, MODULE_CTRL_OFS, 32'h0);
        chk("moduleCtrl", 32'(MODE_ENABLED), rd);
    endtask
    task automatic t_gig();
        logic [4:0] prev;
        int         bad;
        int         moves;
        apb(1'b1, LINK_CFG_OFS, 32'(SPEED_1000));
        repeat (4) @(posedge sys_clk);
        bad = 0;
        moves = 0;
        prev = txOut_ff;
        repeat (16) begin
            @(posedge sys_clk);
            if (txOut_ff !== prev) begin
                moves++;
                bad += (txClk_ff !== 1'b0);
            end
            prev = txOut_ff;
        end
        chk("gig data moves", 32'h1, 32'(moves > 0));
        chk("gig rising moves", 32'h0, 32'(bad));
    endtask
    task automatic t_bad();
        apb(1'b1, 12'h020, 32'hFFFFFFFF);
        chk("write slverr", 32'h1, 32'(er));
        apb(1'b0, 12'h020, 32'h0);
        chk("read slverr", 32'h1, 32'(er));
        chk("read data", 32'h0, rd);
    endtask
    task automatic t_sleep();
        apb(1'b1, DOMAIN_STATE_OFS, 32'(TRANS_SLEEP));
        repeat (3) @(posedge sys_clk);
        chk("ethClkEn sleep", 32'h0, 32'(ethClkEn_ff));
        chk("power kept", 32'h1, 32'(modulePowerOn_ff));
        apb(1'b1, MODULE_CTRL_OFS, 32'(MODE_DISABLED));
        repeat (3) @(posedge sys_clk);
        chk("power off", 32'h0, 32'(modulePowerOn_ff));
        chk("txClk idle", 32'h0, 32'(txClk_ff));
    endtask
    // Clock off, module powered down: status shows only the module-off bit.
    task automatic t_status();
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("status", 32'h0000_0004, rd);
        apb(1'b0, DISABLED_HOURS_OFS, 32'h0);
        chk("disabledHours", 32'h0, rd);
        apb(1'b1, LINK_CFG_OFS, 32'(SPEED_100));
        apb(1'b0, LINK_CFG_OFS, 32'h0);
        chk("linkCfg", 32'(SPEED_100), rd);
    endtask

    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        errorCnt = 0;
        numChecks = 0;
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_wake();
        t_gig();
        t_bad();
        t_sleep();
        t_status();
        reportAndStop();
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        errorCnt++;
        reportAndStop();
    end
endmodule
